// ### hdl/interrupt_vector_and_lowpower_wake.sv
// Fixed-priority interrupt vectoring, enable registers and sleep clock gating.
// Assumes peripheral flags are level requests on ref_clk; the core pulses
// irq_ack when it fetches a vector and irq_return on return from handler.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module interrupt_vector_and_lowpower_wake
  import irq_vector_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic global_int_en,
  input wire logic watchdog_reset_mode,
  input wire logic watchdog_overflow,
  input wire logic flash_key_violation,
  input wire logic reset_pin_reset,
  input wire logic pin_nonmaskable_event,
  input wire logic osc_fault_event,
  input wire logic flash_violation_flag,
  input wire logic second_timer_ch0_flag,
  input wire logic [2:0] second_timer_other_flags,
  input wire logic comparator_flag,
  input wire logic watchdog_interval_flag,
  input wire logic serial_rx_flag,
  input wire logic serial_tx_flag,
  input wire logic converter_done_flags,
  input wire logic first_timer_ch0_flag,
  input wire logic [2:0] first_timer_other_flags,
  input wire logic [7:0] port_one_change_flags,
  input wire logic [2:0] analog_dma_flags,
  input wire logic [7:0] port_two_change_flags,
  input wire logic basic_tick_flag,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_request,
  output logic [15:0] vector_addr,
  output logic [3:0] irq_priority,
  output logic reset_vector_select,
  output logic core_clock_en,
  output logic main_clock_en,
  output logic submain_clock_en,
  output logic aux_clock_en,
  output logic loop_control_en,
  output logic oscillator_clock_en,
  output logic bias_generator_en,
  output logic crystal_en
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] vector_of(input logic [3:0] prio);
    vector_of = VECTOR_BASE + {11'h000, prio, 1'b0};
  endfunction

  logic [7:0] ie_first;
  logic [7:0] ie_second;
  logic watchdog_flag;
  logic pin_nonmaskable_flag;
  logic osc_fault_flag;
  // Starts low so that only the very first reset clears the watchdog flag
  logic power_on_seen = 1'b0;
  power_mode_t sleep_mode;
  power_mode_t saved_mode;
  core_state_t core_state;
  logic [15:0] pending;
  logic any_pending;
  logic [3:0] next_priority;
  logic nmi_clear;
  logic [1:0] flag_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Byte registers at the bottom of the map; no wait states
  assign nmi_clear = reg_write && reg_addr == ADDR_FLAGS_FIRST;
  assign flag_clear = nmi_clear ? ~{reg_wdata[BIT_NMI_IE], reg_wdata[BIT_OSC_IE]} : 2'b00;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ie_first <= IE_RESET;
      ie_second <= IE_RESET;
    end
    else if (reg_write && reg_addr == ADDR_IE_FIRST)
      ie_first <= reg_wdata & IE_FIRST_MASK;
    else if (reg_write && reg_addr == ADDR_IE_SECOND)
      ie_second <= reg_wdata & IE_SECOND_MASK;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        ADDR_IE_FIRST: reg_rdata <= ie_first;
        ADDR_IE_SECOND: reg_rdata <= ie_second;
        ADDR_FLAGS_FIRST: reg_rdata <= {6'h00, osc_fault_flag, watchdog_flag} |
                                       {3'h0, pin_nonmaskable_flag, 4'h0};
        ADDR_POWER_CTRL: reg_rdata <= {5'h00, sleep_mode};
        ADDR_POWER_STATUS: reg_rdata <= {core_state == CORE_SERVICE, saved_mode,
                                         irq_priority};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the clearing cycle wins over the write of zero
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pin_nonmaskable_flag <= 1'b0;
      osc_fault_flag <= 1'b0;
    end
    else
    begin
      pin_nonmaskable_flag <= pin_nonmaskable_event | (pin_nonmaskable_flag & ~flag_clear[1]);
      osc_fault_flag <= osc_fault_event | (osc_fault_flag & ~flag_clear[0]);
    end
  end

  // Watchdog flag survives the core reset; power-on, pin reset or a write of zero to bit 0 clears it
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n && !power_on_seen)
      watchdog_flag <= 1'b0;
    else if ((watchdog_overflow && watchdog_reset_mode) || flash_key_violation)
      watchdog_flag <= 1'b1;
    else if (reset_pin_reset)
      watchdog_flag <= 1'b0;
    else if (nmi_clear && !reg_wdata[0])
      watchdog_flag <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      power_on_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending requests, indexed by priority
  // Module flags are levels and are not latched here: the owning module
  // keeps them until software clears them there
  always_comb
  begin
    pending = 16'h0000;
    pending[PRIO_RESET] = (watchdog_overflow && watchdog_reset_mode) ||
                          flash_key_violation;
    pending[PRIO_NMI] = (pin_nonmaskable_flag && ie_first[BIT_NMI_IE]) ||
                        (osc_fault_flag && ie_first[BIT_OSC_IE]) ||
                        (flash_violation_flag && ie_first[BIT_FLASH_IE]);
    pending[PRIO_TB0] = global_int_en && second_timer_ch0_flag;
    pending[PRIO_TB1] = global_int_en && |second_timer_other_flags;
    pending[PRIO_COMP] = global_int_en && comparator_flag;
    pending[PRIO_WDT] = global_int_en && !watchdog_reset_mode &&
                        watchdog_interval_flag && ie_first[BIT_WDT_IE];
    pending[PRIO_RX] = global_int_en && serial_rx_flag && ie_first[BIT_RX_IE];
    pending[PRIO_TX] = global_int_en && serial_tx_flag && ie_first[BIT_TX_IE];
    pending[PRIO_ADC] = global_int_en && converter_done_flags;
    pending[PRIO_TA0] = global_int_en && first_timer_ch0_flag;
    pending[PRIO_TA1] = global_int_en && |first_timer_other_flags;
    pending[PRIO_P1] = global_int_en && |port_one_change_flags;
    pending[PRIO_DAC] = global_int_en && |analog_dma_flags;
    pending[PRIO_SPARE] = 1'b0;
    pending[PRIO_P2] = global_int_en && |port_two_change_flags;
    pending[PRIO_TICK] = global_int_en && basic_tick_flag &&
                         ie_second[BIT_TICK_IE];
  end

  always_comb
  begin
    next_priority = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (pending[i])
        next_priority = 4'(i);
    end
  end

  assign any_pending = |pending;

  ////////////////////////////////////////////////////////////////////////////
  // Registered vector presented to the core
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irq_request <= 1'b0;
      irq_priority <= PRIO_RESET;
      vector_addr <= vector_of(PRIO_RESET);
      reset_vector_select <= 1'b1;
    end
    else
    begin
      irq_request <= any_pending;
      irq_priority <= next_priority;
      vector_addr <= vector_of(next_priority);
      reset_vector_select <= pending[PRIO_RESET];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep level and wake; the level is restored when the handler returns
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sleep_mode <= ACTIVE_RUNNING;
      saved_mode <= ACTIVE_RUNNING;
      core_state <= CORE_RUN;
    end
    else
    begin
      case (core_state)
        CORE_RUN:
        begin
          if (irq_ack && irq_request)
          begin
            saved_mode <= sleep_mode;
            sleep_mode <= ACTIVE_RUNNING;
            core_state <= CORE_SERVICE;
          end
          else if (reg_write && reg_addr == ADDR_POWER_CTRL && reg_wdata[2:0] <= 3'd5)
            sleep_mode <= power_mode_t'(reg_wdata[2:0]);
        end
        CORE_SERVICE:
        begin
          if (irq_return)
          begin
            sleep_mode <= saved_mode;
            core_state <= CORE_RUN;
          end
        end
        default: core_state <= CORE_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating per operating mode
  always_comb
  begin
    core_clock_en = sleep_mode == ACTIVE_RUNNING;
    main_clock_en = sleep_mode == ACTIVE_RUNNING;
    submain_clock_en = sleep_mode inside {ACTIVE_RUNNING, SLEEP_LEVEL_ZERO,
                                          SLEEP_LEVEL_ONE};
    loop_control_en = sleep_mode inside {ACTIVE_RUNNING, SLEEP_LEVEL_ZERO};
    oscillator_clock_en = sleep_mode inside {ACTIVE_RUNNING, SLEEP_LEVEL_ZERO,
                                             SLEEP_LEVEL_ONE};
    bias_generator_en = !(sleep_mode inside {SLEEP_LEVEL_THREE,
                                             SLEEP_LEVEL_FOUR});
    aux_clock_en = sleep_mode != SLEEP_LEVEL_FOUR;
    crystal_en = sleep_mode != SLEEP_LEVEL_FOUR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector table and slot use
  a_spare_never: assert property (@(posedge ref_clk) disable iff (!reset_n)
    irq_request |-> irq_priority != PRIO_SPARE) else $error("spare slot requested");

  a_vector_matches: assert property (@(posedge ref_clk) disable iff (!reset_n)
    vector_addr == VECTOR_BASE + {11'h000, irq_priority, 1'b0}) else $error("bad vector");

  a_reset_vector: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pending[PRIO_RESET] |=> reset_vector_select && irq_priority == PRIO_RESET)
    else $error("reset vector not selected");

  a_highest_wins: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pending[PRIO_TB0] && !pending[PRIO_RESET] && !pending[PRIO_NMI])
    |=> irq_priority == PRIO_TB0) else $error("priority order broken");

  ////////////////////////////////////////////////////////////////////////////
  // Nonmaskable class: only the own enable counts
  a_nmi_no_gie: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!global_int_en && pin_nonmaskable_flag && ie_first[BIT_NMI_IE] && !pending[PRIO_RESET])
    |=> irq_request && irq_priority == PRIO_NMI) else $error("nmi blocked by gie");

  a_osc_no_gie: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!global_int_en && osc_fault_flag && ie_first[BIT_OSC_IE] && !pending[PRIO_RESET])
    |=> irq_request && irq_priority == PRIO_NMI) else $error("osc fault blocked by gie");

  a_flash_shared: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (flash_violation_flag && ie_first[BIT_FLASH_IE] && !pending[PRIO_RESET])
    |=> irq_request && irq_priority == PRIO_NMI) else $error("flash violation not shared");

  a_nmi_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pin_nonmaskable_event |=> pin_nonmaskable_flag) else $error("pin flag not set");

  a_osc_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    osc_fault_event |=> osc_fault_flag) else $error("osc flag not set");

  a_gie_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!global_int_en && !pending[PRIO_RESET] && !pending[PRIO_NMI]) |=> !irq_request)
    else $error("maskable source passed gie");

  ////////////////////////////////////////////////////////////////////////////
  // Enable bits
  a_rx_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ie_first[BIT_RX_IE] |=> !(irq_request && irq_priority == PRIO_RX))
    else $error("rx not gated");

  a_tx_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ie_first[BIT_TX_IE] |=> !(irq_request && irq_priority == PRIO_TX))
    else $error("tx not gated");

  a_wdt_mode_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    watchdog_reset_mode |-> !pending[PRIO_WDT]) else $error("interval irq in wd mode");

  a_tick_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pending[PRIO_TICK] |-> ie_second[BIT_TICK_IE]) else $error("tick not gated");

  a_ie_first_bits: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ie_first & ~IE_FIRST_MASK) == 8'h00) else $error("unused first enable bit set");

  a_ie_second_bits: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ie_second & ~IE_SECOND_MASK) == 8'h00) else $error("unused second enable bit set");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside its cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog flag
  a_wd_flag_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flash_key_violation |=> watchdog_flag) else $error("watchdog flag not set");

  a_wd_flag_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reset_pin_reset && !flash_key_violation && !(watchdog_overflow && watchdog_reset_mode))
    |=> !watchdog_flag) else $error("watchdog flag not cleared");

  ////////////////////////////////////////////////////////////////////////////
  // Wake, resume and clock gating per level
  a_wake_active: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (core_state == CORE_RUN && irq_ack && irq_request) |=> core_clock_en && main_clock_en)
    else $error("no wake");

  a_service_awake: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (core_state == CORE_SERVICE && !irq_return) |=> sleep_mode == ACTIVE_RUNNING)
    else $error("asleep while servicing");

  a_resume_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (core_state == CORE_SERVICE && irq_return) |=> sleep_mode == $past(saved_mode))
    else $error("sleep level not restored");

  a_active_all: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_mode == ACTIVE_RUNNING |-> core_clock_en && main_clock_en && submain_clock_en &&
    aux_clock_en && loop_control_en && oscillator_clock_en && bias_generator_en && crystal_en)
    else $error("active clocks stopped");

  a_level_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_mode == SLEEP_LEVEL_ZERO |-> !core_clock_en && !main_clock_en &&
    aux_clock_en && submain_clock_en && loop_control_en) else $error("level zero clocks");

  a_level_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_mode == SLEEP_LEVEL_ONE |-> !main_clock_en && !loop_control_en &&
    aux_clock_en && submain_clock_en) else $error("level one clocks");

  a_level_two: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_mode == SLEEP_LEVEL_TWO |-> !main_clock_en && !loop_control_en &&
    !oscillator_clock_en && bias_generator_en && aux_clock_en) else $error("level two clocks");

  a_level_three: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_mode == SLEEP_LEVEL_THREE |-> !oscillator_clock_en && !bias_generator_en &&
    aux_clock_en && crystal_en) else $error("level three clocks");

  a_level_four: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sleep_mode == SLEEP_LEVEL_FOUR |-> !aux_clock_en && !crystal_en && !bias_generator_en)
    else $error("level four clocks run");
endmodule

// ### hdl/irq_vector_pkg.sv
// Constants for the interrupt vectoring and low-power wake block.
// Assumes a single 20 MHz clock and a synchronous active-low reset.
// Summary of operation
// - Vectors occupy top words, lowest at 0FFE0h
// - Each vector slot holds 16-bit handler address
// - Reset sources select 0FFFEh, priority 15
// - Pin, oscillator, flash faults share 0FFFCh
// - Nonmaskable class ignores global enable
// - Second timer channel 0 uses 0FFFAh
// - Second timer others share 0FFF8h
// - Converter done flags use 0FFEEh
// - First timer channel 0 uses 0FFECh
// - First timer others share 0FFEAh
// - Port one changes share 0FFE8h
// - Analog outputs and DMA share 0FFE6h
// - Port two changes share 0FFE2h
// - First enable bit 6 gates receive
// - First enable bit 7 gates transmit
// - First enable bit 0 gates interval timer
// - Bits 1,4,5 enable nonmaskable sources
// - Second enable bit 7 gates basic tick
// - Byte-wide registers at lowest addresses
// - Enabled event wakes; return resumes sleep
// - Active, levels zero and one clock gating
// - Levels two to four clock gating
// - Watchdog flag set and clear causes
package irq_vector_pkg;
  localparam logic [15:0] VECTOR_BASE = 16'hFFE0;
  localparam logic [7:0] ADDR_IE_FIRST = 8'h00;
  localparam logic [7:0] ADDR_IE_SECOND = 8'h01;
  localparam logic [7:0] ADDR_FLAGS_FIRST = 8'h02;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h04;
  localparam logic [7:0] ADDR_POWER_STATUS = 8'h05;
  localparam int BIT_WDT_IE = 0;
  localparam int BIT_OSC_IE = 1;
  localparam int BIT_NMI_IE = 4;
  localparam int BIT_FLASH_IE = 5;
  localparam int BIT_RX_IE = 6;
  localparam int BIT_TX_IE = 7;
  localparam int BIT_TICK_IE = 7;
  localparam logic [7:0] IE_FIRST_MASK = 8'hF3;
  localparam logic [7:0] IE_SECOND_MASK = 8'h80;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [3:0] PRIO_RESET = 4'hF;
  localparam logic [3:0] PRIO_NMI = 4'hE;
  localparam logic [3:0] PRIO_TB0 = 4'hD;
  localparam logic [3:0] PRIO_TB1 = 4'hC;
  localparam logic [3:0] PRIO_COMP = 4'hB;
  localparam logic [3:0] PRIO_WDT = 4'hA;
  localparam logic [3:0] PRIO_RX = 4'h9;
  localparam logic [3:0] PRIO_TX = 4'h8;
  localparam logic [3:0] PRIO_ADC = 4'h7;
  localparam logic [3:0] PRIO_TA0 = 4'h6;
  localparam logic [3:0] PRIO_TA1 = 4'h5;
  localparam logic [3:0] PRIO_P1 = 4'h4;
  localparam logic [3:0] PRIO_DAC = 4'h3;
  localparam logic [3:0] PRIO_SPARE = 4'h2;
  localparam logic [3:0] PRIO_P2 = 4'h1;
  localparam logic [3:0] PRIO_TICK = 4'h0;
  typedef enum logic [2:0] {
    ACTIVE_RUNNING, SLEEP_LEVEL_ZERO, SLEEP_LEVEL_ONE,
    SLEEP_LEVEL_TWO, SLEEP_LEVEL_THREE, SLEEP_LEVEL_FOUR
  } power_mode_t;
  typedef enum logic [1:0] {CORE_RUN, CORE_SERVICE} core_state_t;
endpackage

// ### bench/core_model.sv
// Processor core stand-in: fetches a vector when asked and returns later.
// Assumes the block's single clock and synchronous active-low reset.
`timescale 1ns/1ps
module core_model #(
  parameter int SERVICE_CYCLES = 12
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic respond,
  input wire logic irq_request,
  output logic irq_ack,
  output logic irq_return
);
  int cnt;
  logic busy;
  // A one-cycle fetch pulse, then a handler of fixed length before returning
  always_ff @(posedge ref_clk)
  begin
    irq_ack <= 1'b0;
    irq_return <= 1'b0;
    if (!reset_n)
    begin
      busy <= 1'b0;
      cnt <= 0;
    end
    else if (!busy && respond && irq_request && !irq_ack)
    begin
      irq_ack <= 1'b1;
      busy <= 1'b1;
      cnt <= 0;
    end
    else if (busy)
    begin
      cnt <= cnt + 1;
      if (cnt == SERVICE_CYCLES)
      begin
        irq_return <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// ### bench/interrupt_vector_and_lowpower_wake_tb_top.sv
// Self-checking bench for the interrupt vectoring and sleep clock block.
// Assumes a 20 MHz clock; register reads are checked from a queue.
`timescale 1ns/1ps
module interrupt_vector_and_lowpower_wake_tb_top;
  import irq_vector_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, r;
  logic gie = 1'b0, wrm = 1'b0, wov = 1'b0, fkv = 1'b0, rpr = 1'b0, respond = 1'b0;
  logic [2:0] nm = 3'h0;
  logic [32:0] src = '0;
  logic irq_ack, irq_return, irq_request, rsel, rd_q = 1'b0;
  logic [15:0] vector_addr;
  logic [3:0] irq_priority;
  logic [7:0] clkv, e;
  logic [7:0] mexp [6] = '{8'hFF, 8'h3F, 8'h37, 8'h33, 8'h31, 8'h00};
  logic [7:0] nie [3] = '{8'h10, 8'h02, 8'h20};
  logic [7:0] exp_q [$];
  int err_count = 0, num_checks = 0, cycles = 0, i, k;
  always #25 ref_clk = ~ref_clk;
  interrupt_vector_and_lowpower_wake interrupt_vector_and_lowpower_wake_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .global_int_en(gie),
    .watchdog_reset_mode(wrm), .watchdog_overflow(wov), .flash_key_violation(fkv),
    .reset_pin_reset(rpr), .pin_nonmaskable_event(nm[0]), .osc_fault_event(nm[1]),
    .flash_violation_flag(nm[2]), .second_timer_ch0_flag(src[0]),
    .second_timer_other_flags(src[3:1]), .comparator_flag(src[4]),
    .watchdog_interval_flag(src[5]), .serial_rx_flag(src[6]), .serial_tx_flag(src[7]),
    .converter_done_flags(src[8]), .first_timer_ch0_flag(src[9]),
    .first_timer_other_flags(src[12:10]), .port_one_change_flags(src[20:13]),
    .analog_dma_flags(src[23:21]), .port_two_change_flags(src[31:24]),
    .basic_tick_flag(src[32]), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_request(irq_request), .vector_addr(vector_addr), .irq_priority(irq_priority),
    .reset_vector_select(rsel), .core_clock_en(clkv[7]), .main_clock_en(clkv[6]),
    .submain_clock_en(clkv[5]), .aux_clock_en(clkv[4]), .loop_control_en(clkv[3]),
    .oscillator_clock_en(clkv[2]), .bias_generator_en(clkv[1]), .crystal_en(clkv[0]));
  core_model core_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .respond(respond),
    .irq_request(irq_request), .irq_ack(irq_ack), .irq_return(irq_return));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] s);
    num_checks++;
    if (s !== ex)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, ex, s);
    end
  endtask
  task automatic chk_irq(input logic [3:0] p);
    chk("irq_request", 16'h0001, {15'h0, irq_request});
    chk("irq_priority", {12'h0, p}, {12'h0, irq_priority});
    chk("vector_addr", VECTOR_BASE + {11'h0, p, 1'b0}, vector_addr);
  endtask
  task automatic chk_clk(input logic [7:0] ex, input logic [7:0] m);
    chk("clock_enables", {8'h00, ex & m}, {8'h00, clkv & m});
  endtask
  // Bytes only: a whole register in one strobe
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] ex);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(ex);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [3:0] prio_of(input int b);
    if (b == 0) return PRIO_TB0;
    if (b <= 3) return PRIO_TB1;
    if (b == 4) return PRIO_COMP;
    if (b == 5) return PRIO_WDT;
    if (b == 6) return PRIO_RX;
    if (b == 7) return PRIO_TX;
    if (b == 8) return PRIO_ADC;
    if (b == 9) return PRIO_TA0;
    if (b <= 12) return PRIO_TA1;
    if (b <= 20) return PRIO_P1;
    if (b <= 23) return PRIO_DAC;
    if (b <= 31) return PRIO_P2;
    return PRIO_TICK;
  endfunction
  task automatic summarize;
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe, so compare right then
  always @(posedge ref_clk)
  begin
    if (rd_q)
    begin
      e = exp_q.pop_front();
      chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    end
    rd_q = reg_read;
    cycles++;
    if (cycles > 6000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(32'hCB91));
    repeat (6) @(posedge ref_clk);
    #1;
    chk("irq_request", 16'h0000, {15'h0, irq_request});
    chk("irq_priority", {12'h0, PRIO_RESET}, {12'h0, irq_priority});
    chk("vector_addr", 16'hFFFE, vector_addr);
    chk("reset_vector_select", 16'h0001, {15'h0, rsel});
    @(posedge ref_clk) reset_n <= 1'b1;
    rreg(ADDR_IE_FIRST, 8'h00);
    rreg(ADDR_IE_SECOND, 8'h00);
    r = 8'($urandom);
    wreg(ADDR_IE_FIRST, r);
    rreg(ADDR_IE_FIRST, r & IE_FIRST_MASK);
    wreg(8'h0F, 8'hFF);
    rreg(8'h0F, 8'h00);
    wreg(ADDR_IE_SECOND, 8'hFF);
    rreg(ADDR_IE_SECOND, 8'h80);
    wreg(ADDR_IE_FIRST, 8'hF3);
    gie <= 1'b1;
    for (i = 0; i < 33; i++)
    begin
      @(posedge ref_clk) src <= 33'(1) << i;
      settle();
      chk_irq(prio_of(i));
    end
    @(posedge ref_clk) src <= '1;
    settle();
    chk_irq(PRIO_TB0);
    @(posedge ref_clk) gie <= 1'b0;
    settle();
    chk("irq_request", 16'h0000, {15'h0, irq_request});
    wreg(ADDR_IE_FIRST, 8'h00);
    wreg(ADDR_IE_SECOND, 8'h00);
    src <= 33'h1_0000_00E0;
    gie <= 1'b1;
    settle();
    chk("irq_request", 16'h0000, {15'h0, irq_request});
    wreg(ADDR_IE_SECOND, 8'h80);
    settle();
    chk_irq(PRIO_TICK);
    wreg(ADDR_IE_FIRST, 8'h01);
    settle();
    chk_irq(PRIO_WDT);
    @(posedge ref_clk) wrm <= 1'b1;
    settle();
    chk_irq(PRIO_TICK);
    wreg(ADDR_IE_FIRST, 8'h40);
    settle();
    chk_irq(PRIO_RX);
    wreg(ADDR_IE_FIRST, 8'h80);
    settle();
    chk_irq(PRIO_TX);
    src <= '0;
    gie <= 1'b0;
    for (k = 0; k < 3; k++)
    begin
      wreg(ADDR_IE_FIRST, nie[k]);
      nm <= 3'(1) << k;
      @(posedge ref_clk) nm[1:0] <= 2'b00;
      settle();
      chk_irq(PRIO_NMI);
      wreg(ADDR_IE_FIRST, 8'h00);
      settle();
      chk("irq_request", 16'h0000, {15'h0, irq_request});
      nm <= 3'h0;
      wreg(ADDR_FLAGS_FIRST, 8'h00);
    end
    for (k = 0; k < 2; k++)
    begin
      @(posedge ref_clk) {fkv, wov} <= 2'(1) << k;
      settle();
      chk("reset_vector_select", 16'h0001, {15'h0, rsel});
      chk_irq(PRIO_RESET);
      @(posedge ref_clk) {fkv, wov} <= 2'b00;
      rreg(ADDR_FLAGS_FIRST, 8'h01);
      @(posedge ref_clk) rpr <= 1'b1;
      @(posedge ref_clk) rpr <= 1'b0;
      settle();
      chk("reset_vector_select", 16'h0000, {15'h0, rsel});
      rreg(ADDR_FLAGS_FIRST, 8'h00);
    end
    wrm <= 1'b0;
    gie <= 1'b1;
    for (k = 0; k < 6; k++)
    begin
      wreg(ADDR_POWER_CTRL, 8'(k));
      settle();
      chk_clk(mexp[k], (k > 2) ? 8'hDF : 8'hFF);
    end
    wreg(ADDR_POWER_CTRL, 8'h04);
    wreg(ADDR_POWER_CTRL, 8'h07);
    rreg(ADDR_POWER_CTRL, 8'h04);
    wreg(ADDR_IE_FIRST, 8'h40);
    respond <= 1'b1;
    src[6] <= 1'b1;
    // Look a little after each edge so the core's one-cycle pulse has settled
    for (i = 0; i < 50 && irq_ack !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk("irq_ack", 16'h0001, {15'h0, irq_ack});
    src[6] <= 1'b0;
    settle();
    chk_clk(8'hFF, 8'hFF);
    for (i = 0; i < 50 && irq_return !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    respond <= 1'b0;
    settle();
    chk_clk(mexp[4], 8'hDF);
    summarize();
  end
endmodule
